/* File: core/mbf_bridge.sv */
// Bridge forwarding filter: address table, forwarding and multicast tracking.
module mbf_bridge #(
  parameter int unsigned SEC_CYC = mbf_pkg::SEC_CYC_DEF,
  parameter int unsigned STALE_CYC = mbf_pkg::STALE_CYC_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cfg_single_user,
  input wire logic cfg_learn_en,
  input wire logic cfg_override_en,
  input wire logic [15:0] cfg_query_interval,
  input wire logic [7:0] cfg_response_interval,
  input wire logic prov_wr_valid,
  input wire logic [47:0] prov_wr_mac,
  input wire logic frm_valid,
  input wire logic frm_from_cable,
  input wire logic [47:0] frm_dst,
  input wire logic [47:0] frm_src,
  input wire logic [3:0] frm_flow,
  input wire logic frm_policy_ok,
  output logic frm_ready,
  input wire logic qry_valid,
  input wire logic [7:0] qry_resp_sec,
  input wire logic rpt_valid,
  input wire logic [22:0] rpt_group,
  output logic out_valid,
  input wire logic out_ready,
  output logic out_to_cable,
  output logic [3:0] out_flow,
  output logic [47:0] out_dst,
  output logic [47:0] out_src,
  output logic stale_drop,
  output logic filter_drop,
  output logic [2:0] table_count,
  output logic table_full,
  output logic [15:0] query_interval,
  output logic [7:0] response_interval
);

  // ==========================================================
  // State
  logic [47:0] sup_mac_ff [mbf_pkg::MAX_SUP];
  logic [mbf_pkg::MAX_SUP-1:0] sup_valid_ff;
  logic [mbf_pkg::MAX_SUP-1:0] sup_prov_ff;
  logic [47:0] loc_mac_ff [mbf_pkg::MAX_LOC];
  logic [mbf_pkg::MAX_LOC-1:0] loc_valid_ff;
  logic [1:0] loc_ptr_ff;
  logic [22:0] grp_addr_ff [mbf_pkg::MAX_GRP];
  logic [17:0] grp_timer_ff [mbf_pkg::MAX_GRP];
  logic [mbf_pkg::MAX_GRP-1:0] grp_valid_ff;
  logic [100:0] fifo_ff [mbf_pkg::FIFO_DEPTH];
  logic fifo_wp_ff;
  logic fifo_rp_ff;
  logic [1:0] fifo_cnt_ff;
  logic [1:0] nxt_fifo_cnt;
  logic frm_ready_ff;
  logic out_valid_ff;
  logic [100:0] out_ent_ff;
  logic [31:0] age_ff;
  logic stale_drop_ff;
  logic filter_drop_ff;
  logic [31:0] tick_cnt_ff;
  logic tick_ff;
  logic [15:0] sec_ff;
  logic [15:0] last_q_ff;
  logic [1:0] q_seen_ff;
  logic [15:0] qi_ff;
  logic [7:0] ri_ff;
  logic [15:0] query_interval_ff;
  logic [7:0] response_interval_ff;
  logic [2:0] table_count_ff;
  logic table_full_ff;

  // ==========================================================
  // Lookup helpers over the module tables
  function automatic logic sup_hit(input logic [47:0] mac);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < mbf_pkg::MAX_SUP; i++) begin
      if (sup_valid_ff[i] && sup_mac_ff[i] == mac) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  function automatic logic loc_hit(input logic [47:0] mac);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < mbf_pkg::MAX_LOC; i++) begin
      if (loc_valid_ff[i] && loc_mac_ff[i] == mac) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  function automatic logic grp_hit(input logic [22:0] grp);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < mbf_pkg::MAX_GRP; i++) begin
      if (grp_valid_ff[i] && grp_addr_ff[i] == grp) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  // ==========================================================
  // Table occupancy and free-slot search
  logic [2:0] cap;
  logic full_now;
  logic sup_free_any;
  logic [1:0] sup_free_idx;
  logic sup_lrn_any;
  logic [1:0] sup_lrn_idx;
  logic [1:0] prov_match_idx;
  logic prov_match;

  // Single-user mode caps the table at one entry.
  assign cap = cfg_single_user ? 3'h1 : 3'(mbf_pkg::MAX_SUP);
  assign full_now = (table_count_ff >= cap);

  always_comb begin
    sup_free_any = 1'b0;
    sup_free_idx = 2'h0;
    sup_lrn_any = 1'b0;
    sup_lrn_idx = 2'h0;
    prov_match = 1'b0;
    prov_match_idx = 2'h0;
    for (int i = mbf_pkg::MAX_SUP - 1; i >= 0; i--) begin
      if (!sup_valid_ff[i]) begin
        sup_free_any = 1'b1;
        sup_free_idx = 2'(i);
      end
      if (sup_valid_ff[i] && !sup_prov_ff[i]) begin
        sup_lrn_any = 1'b1;
        sup_lrn_idx = 2'(i);
      end
      if (sup_valid_ff[i] && sup_mac_ff[i] == prov_wr_mac) begin
        prov_match = 1'b1;
        prov_match_idx = 2'(i);
      end
    end
  end

  // ==========================================================
  // Forwarding decision for the offered frame
  logic frm_take;
  logic src_sup;
  logic learn_now;
  logic loc_learn;
  logic is_bcast;
  logic is_mcast;
  logic fwd;

  // Provisioning owns the table, so a frame waits a cycle.
  assign frm_take = frm_valid && frm_ready_ff && !prov_wr_valid;
  assign is_bcast = (frm_dst == mbf_pkg::BCAST_MAC);
  assign is_mcast = frm_dst[mbf_pkg::MCAST_BIT] && !is_bcast;
  assign src_sup = sup_hit(frm_src);
  // A new Ethernet source is learned only while room remains.
  assign learn_now = !frm_from_cable && !src_sup && cfg_learn_en && !full_now && sup_free_any;
  // Sources that cannot be supported go to the local table instead.
  assign loc_learn = !frm_from_cable && !src_sup && !learn_now && !loc_hit(frm_src);

  always_comb begin
    if (frm_from_cable) begin
      if (is_bcast) begin
        fwd = !src_sup;
      end else if (is_mcast) begin
        fwd = frm_policy_ok && grp_hit(frm_dst[22:0]);
      end else begin
        fwd = sup_hit(frm_dst);
      end
    end else if (!(src_sup || learn_now)) begin
      fwd = 1'b0;
    end else if (is_bcast) begin
      fwd = 1'b1;
    end else if (is_mcast) begin
      fwd = frm_policy_ok;
    end else begin
      // Known local destinations stay on the segment; unknown ones go upstream.
      fwd = !loc_hit(frm_dst) && !sup_hit(frm_dst);
    end
  end

  // ==========================================================
  // Supported address table; only reset empties it, no aging.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sup_valid_ff <= '0;
      sup_prov_ff <= '0;
      for (int i = 0; i < mbf_pkg::MAX_SUP; i++) begin
        sup_mac_ff[i] <= '0;
      end
    end else if (prov_wr_valid) begin
      if (prov_match) begin
        sup_prov_ff[prov_match_idx] <= 1'b1;
      end else if (!full_now && sup_free_any) begin
        sup_valid_ff[sup_free_idx] <= 1'b1;
        sup_prov_ff[sup_free_idx] <= 1'b1;
        sup_mac_ff[sup_free_idx] <= prov_wr_mac;
      end else if (sup_lrn_any) begin
        sup_prov_ff[sup_lrn_idx] <= 1'b1;
        sup_mac_ff[sup_lrn_idx] <= prov_wr_mac;
      end
    end else if (frm_take && learn_now) begin
      sup_valid_ff[sup_free_idx] <= 1'b1;
      sup_prov_ff[sup_free_idx] <= 1'b0;
      sup_mac_ff[sup_free_idx] <= frm_src;
    end
  end

  // Occupancy follows the valid bits one cycle later.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      table_count_ff <= '0;
      table_full_ff <= 1'b0;
    end else begin
      table_count_ff <= 3'($countones(sup_valid_ff));
      table_full_ff <= (3'($countones(sup_valid_ff)) >= cap);
    end
  end

  // ==========================================================
  // Local device table, round-robin like a learning bridge.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      loc_valid_ff <= '0;
      loc_ptr_ff <= '0;
      for (int i = 0; i < mbf_pkg::MAX_LOC; i++) begin
        loc_mac_ff[i] <= '0;
      end
    end else if (frm_take && loc_learn) begin
      loc_valid_ff[loc_ptr_ff] <= 1'b1;
      loc_mac_ff[loc_ptr_ff] <= frm_src;
      loc_ptr_ff <= loc_ptr_ff + 2'h1;
    end
  end

  // ==========================================================
  // Two-entry buffer; one push per accepted frame keeps copies single.
  logic push;
  logic pop;
  logic out_load;
  logic stale_hit;

  assign stale_hit = out_valid_ff && !out_ready && (age_ff == STALE_CYC - 1);
  assign out_load = !out_valid_ff || out_ready || stale_hit;
  assign push = frm_take && fwd;
  assign pop = out_load && (fifo_cnt_ff != 2'h0);

  always_comb begin
    nxt_fifo_cnt = fifo_cnt_ff;
    if (push && !pop) begin
      nxt_fifo_cnt = fifo_cnt_ff + 2'h1;
    end else if (pop && !push) begin
      nxt_fifo_cnt = fifo_cnt_ff - 2'h1;
    end
  end

  // Registered ready from the next count: a draining buffer reopens on the edge that pops it.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fifo_wp_ff <= 1'b0;
      fifo_rp_ff <= 1'b0;
      fifo_cnt_ff <= '0;
      frm_ready_ff <= 1'b1;
      fifo_ff[0] <= '0;
      fifo_ff[1] <= '0;
    end else begin
      if (push) begin
        fifo_ff[fifo_wp_ff] <= {!frm_from_cable, frm_flow, frm_src, frm_dst};
        fifo_wp_ff <= !fifo_wp_ff;
      end
      if (pop) begin
        fifo_rp_ff <= !fifo_rp_ff;
      end
      fifo_cnt_ff <= nxt_fifo_cnt;
      frm_ready_ff <= (nxt_fifo_cnt != 2'(mbf_pkg::FIFO_DEPTH));
    end
  end

  // Dropped-by-filter pulse, one per refused frame.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      filter_drop_ff <= 1'b0;
    end else begin
      filter_drop_ff <= frm_take && !fwd;
    end
  end

  // ==========================================================
  // Output stage; a stuck frame is discarded, not sent late.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_valid_ff <= 1'b0;
      out_ent_ff <= '0;
      age_ff <= '0;
      stale_drop_ff <= 1'b0;
    end else begin
      stale_drop_ff <= stale_hit;
      if (out_load) begin
        out_valid_ff <= pop;
        age_ff <= '0;
        if (pop) begin
          out_ent_ff <= fifo_ff[fifo_rp_ff];
        end
      end else begin
        age_ff <= age_ff + 32'h1;
      end
    end
  end

  // ==========================================================
  // Seconds tick from the system clock.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_cnt_ff <= '0;
      tick_ff <= 1'b0;
      sec_ff <= '0;
    end else if (tick_cnt_ff == SEC_CYC - 1) begin
      tick_cnt_ff <= '0;
      tick_ff <= 1'b1;
      sec_ff <= sec_ff + 16'h1;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 32'h1;
      tick_ff <= 1'b0;
    end
  end

  // ==========================================================
  // Passive query interval and response interval derivation.
  logic [15:0] q_gap;
  logic [15:0] qi_eff;
  logic [7:0] ri_eff;
  logic [17:0] memb_reload;

  assign q_gap = sec_ff - last_q_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q_seen_ff <= '0;
      last_q_ff <= '0;
      qi_ff <= mbf_pkg::QI_DEF_S;
      ri_ff <= mbf_pkg::RI_DEF_S;
    end else if (qry_valid) begin
      last_q_ff <= sec_ff;
      if (q_seen_ff != mbf_pkg::QRY_SEEN_MIN) begin
        q_seen_ff <= q_seen_ff + 2'h1;
      end
      // From the second query on, the gap counts.
      if (q_seen_ff != 2'h0) begin
        qi_ff <= (q_gap > mbf_pkg::QI_DEF_S) ? q_gap : mbf_pkg::QI_DEF_S;
      end
      ri_ff <= (qry_resp_sec == 8'h00) ? mbf_pkg::RI_DEF_S : qry_resp_sec;
    end
  end

  // The override replaces both timers only while enabled.
  assign qi_eff = cfg_override_en ? cfg_query_interval : qi_ff;
  assign ri_eff = cfg_override_en ? cfg_response_interval : ri_ff;
  assign memb_reload = {1'b0, qi_eff, 1'b0} + {10'h000, ri_eff};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      query_interval_ff <= mbf_pkg::QI_DEF_S;
      response_interval_ff <= mbf_pkg::RI_DEF_S;
    end else begin
      query_interval_ff <= qi_eff;
      response_interval_ff <= ri_eff;
    end
  end

  // ==========================================================
  // Group membership table. A report beats the tick that would expire it.
  logic rpt_match;
  logic [1:0] rpt_idx;
  logic grp_free_any;
  logic [1:0] grp_free_idx;

  always_comb begin
    rpt_match = 1'b0;
    rpt_idx = 2'h0;
    grp_free_any = 1'b0;
    grp_free_idx = 2'h0;
    for (int i = mbf_pkg::MAX_GRP - 1; i >= 0; i--) begin
      if (!grp_valid_ff[i]) begin
        grp_free_any = 1'b1;
        grp_free_idx = 2'(i);
      end
      if (grp_valid_ff[i] && grp_addr_ff[i] == rpt_group) begin
        rpt_match = 1'b1;
        rpt_idx = 2'(i);
      end
    end
  end

  // With every slot busy a report for a new group is ignored.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      grp_valid_ff <= '0;
      for (int i = 0; i < mbf_pkg::MAX_GRP; i++) begin
        grp_addr_ff[i] <= '0;
        grp_timer_ff[i] <= '0;
      end
    end else begin
      for (int i = 0; i < mbf_pkg::MAX_GRP; i++) begin
        if (rpt_valid && ((rpt_match && rpt_idx == 2'(i)) ||
            (!rpt_match && grp_free_any && grp_free_idx == 2'(i)))) begin
          grp_valid_ff[i] <= 1'b1;
          grp_addr_ff[i] <= rpt_group;
          grp_timer_ff[i] <= memb_reload;
        end else if (tick_ff && grp_valid_ff[i]) begin
          grp_timer_ff[i] <= grp_timer_ff[i] - 18'h1;
          if (grp_timer_ff[i] <= 18'h1) begin
            grp_valid_ff[i] <= 1'b0;
          end
        end
      end
    end
  end

  // ==========================================================
  // Output drive.
  assign frm_ready = frm_ready_ff;
  assign out_valid = out_valid_ff;
  assign out_to_cable = out_ent_ff[100];
  assign out_flow = out_ent_ff[99:96];
  assign out_src = out_ent_ff[95:48];
  assign out_dst = out_ent_ff[47:0];
  assign stale_drop = stale_drop_ff;
  assign filter_drop = filter_drop_ff;
  assign table_count = table_count_ff;
  assign table_full = table_full_ff;
  assign query_interval = query_interval_ff;
  assign response_interval = response_interval_ff;

endmodule // mbf_bridge

/* File: core/mbf_pkg.sv */
// Constants shared by the modem bridge forwarding filter.
// Summary of operation
// - Fill address table from provisioning or learning.
// - Full table replaces only learned entries, on provisioning.
// - Table holds at least one entry.
// - Provisioning writes accepted up to table maximum.
// - Provisioned entries beat learned entries.
// - Table entries never age out.
// - Reset clears every provisioned and learned entry.
// - Each received frame leaves at most once.
// - Frames waiting too long are dropped.
// - Frames leave in arrival order.
// - Cable unicast to unknown destination dropped.
// - Cable broadcast passes unless source is supported.
// - Cable multicast needs policy and membership permit.
// - Ethernet unknown destinations go to cable.
// - Ethernet broadcast goes to cable after source check.
// - Ethernet multicast follows operator filter setting.
// - Unsupported Ethernet sources never reach cable.
// - Single user: one source, others learned locally.
// - Supported-to-local-device traffic is filtered.
// - Query interval 125 s, then max of gap.
// - Response interval from query, zero means 10 s.
// - Timers work unconfigured, optional override offered.
// - Ethernet report enables group cable-to-Ethernet forwarding.
// - Group expires after twice query plus response interval.
package mbf_pkg;
  // ==========================================================
  // Clock and timing
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned SEC_CYC_DEF = CLK_HZ;
  localparam int unsigned STALE_MS = 2;
  localparam int unsigned STALE_CYC_DEF = (STALE_MS * CLK_HZ) / 1000;
  // ==========================================================
  // Table sizes and field widths
  localparam int unsigned MAX_SUP = 4;
  localparam int unsigned MAX_LOC = 4;
  localparam int unsigned MAX_GRP = 4;
  localparam int unsigned MAC_W = 48;
  localparam int unsigned GRP_W = 23;
  localparam int unsigned FLOW_W = 4;
  localparam int unsigned SEC_W = 16;
  localparam int unsigned RI_W = 8;
  localparam int unsigned MEMB_W = 18;
  localparam int unsigned CNT_W = 3;
  localparam int unsigned ENT_W = 1 + FLOW_W + 2 * MAC_W;
  localparam int unsigned FIFO_DEPTH = 2;
  // ==========================================================
  // Address fields and multicast timer values
  localparam logic [47:0] BCAST_MAC = 48'hFFFF_FFFF_FFFF;
  localparam int unsigned MCAST_BIT = 40;
  localparam logic [15:0] QI_DEF_S = 16'h007D;
  localparam logic [7:0] RI_DEF_S = 8'h0A;
  localparam logic [1:0] QRY_SEEN_MIN = 2'h2;
endpackage : mbf_pkg

/* File: verif/mbf_bridge_monitor.sv */
// Concurrent checks on the ports of the bridge forwarding filter.
module mbf_bridge_monitor #(
  parameter int unsigned STALE_CYC = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cfg_override_en,
  input wire logic prov_wr_valid,
  input wire logic frm_valid,
  input wire logic frm_ready,
  input wire logic qry_valid,
  input wire logic [7:0] qry_resp_sec,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic out_to_cable,
  input wire logic [3:0] out_flow,
  input wire logic [47:0] out_dst,
  input wire logic [47:0] out_src,
  input wire logic stale_drop,
  input wire logic filter_drop,
  input wire logic [2:0] table_count,
  input wire logic table_full,
  input wire logic [15:0] query_interval,
  input wire logic [7:0] response_interval
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // Helper logic
  logic tk;
  logic [1:0] dec;
  logic [7:0] held_ff;
  logic [2:0] pend_ff;
  logic [7:0] resp_ff;
  // Taken minus left frames; a surplus exit means a copy.
  assign tk = frm_valid && frm_ready && !prov_wr_valid;
  assign dec = 2'(out_valid && out_ready) + 2'(filter_drop) + 2'(stale_drop);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_ff <= 3'h0;
    end else begin
      pend_ff <= pend_ff + 3'(tk) - 3'(dec);
    end
  end
  // Current stall length, restarted after each age drop.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      held_ff <= 8'h00;
    end else if (out_valid && !out_ready && !stale_drop) begin
      held_ff <= held_ff + 8'h01;
    end else begin
      held_ff <= 8'h00;
    end
  end
  // Response interval asked by the last query; zero means default.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      resp_ff <= mbf_pkg::RI_DEF_S;
    end else if (qry_valid) begin
      resp_ff <= (qry_resp_sec == 8'h00) ? mbf_pkg::RI_DEF_S : qry_resp_sec;
    end
  end
  // ==========================================================
  // Assertions
  property p_rst_vals;
    $fell(rst) |-> table_count == 3'h0 && !out_valid && query_interval == mbf_pkg::QI_DEF_S;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("reset state wrong");
  property p_no_dup;
    {1'b0, dec} <= pend_ff;
  endproperty
  a_no_dup: assert property (p_no_dup) else $error("frame copied");
  property p_out_hold;
    out_valid && !out_ready |=> stale_drop || (out_valid && $stable(out_dst) &&
      $stable(out_src) && $stable(out_flow) && $stable(out_to_cable));
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("held frame changed");
  property p_stale_bound;
    held_ff <= 8'(STALE_CYC + 1);
  endproperty
  a_stale_bound: assert property (p_stale_bound) else $error("stale frame kept");
  property p_stale_cause;
    stale_drop |-> $past(out_valid && !out_ready);
  endproperty
  a_stale_cause: assert property (p_stale_cause) else $error("drop without stall");
  property p_filt_cause;
    filter_drop |-> $past(tk);
  endproperty
  a_filt_cause: assert property (p_filt_cause) else $error("filter without frame");
  property p_count_mono;
    table_count >= $past(table_count);
  endproperty
  a_count_mono: assert property (p_count_mono) else $error("table entry lost");
  property p_prov_count;
    prov_wr_valid |-> ##2 table_count != 3'h0;
  endproperty
  a_prov_count: assert property (p_prov_count) else $error("provisioning not held");
  property p_qi_floor;
    !cfg_override_en && !$past(cfg_override_en) && !$past(cfg_override_en, 2) |->
      query_interval >= mbf_pkg::QI_DEF_S;
  endproperty
  a_qi_floor: assert property (p_qi_floor) else $error("query interval below floor");
  property p_resp_load;
    qry_valid && !cfg_override_en |-> ##[1:2] response_interval == resp_ff;
  endproperty
  a_resp_load: assert property (p_resp_load) else $error("response interval wrong");
endmodule // mbf_bridge_monitor

bind mbf_bridge mbf_bridge_monitor #(.STALE_CYC(STALE_CYC)) mbf_bridge_monitor_i (.*);

/* File: verif/mbf_bridge_tb_top.sv */
// Self-checking bench for the bridge forwarding filter.
module mbf_bridge_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [47:0] MA = 48'h0200_0000_00A1;
  localparam logic [47:0] MB = 48'h0200_0000_00B2;
  localparam logic [47:0] MC = 48'h0200_0000_00C3;
  localparam logic [47:0] MD = 48'h0200_0000_00D4;
  localparam logic [47:0] ME = 48'h0200_0000_00E5;
  localparam logic [47:0] MF = 48'h0200_0000_00F6;
  localparam logic [47:0] MH = 48'h0200_0000_0017;
  localparam logic [47:0] MP = 48'h0200_0000_0028;
  localparam logic [47:0] MX = 48'h0200_0000_0F0F;
  localparam logic [47:0] MG = 48'h0100_5E00_0007;
  logic clk, rst, cfg_single_user, cfg_learn_en, cfg_override_en, prov_wr_valid;
  logic frm_valid, frm_from_cable, frm_policy_ok, frm_ready, qry_valid, rpt_valid;
  logic out_valid, out_ready, out_to_cable, stale_drop, filter_drop, table_full;
  logic [15:0] cfg_query_interval, query_interval;
  logic [7:0] cfg_response_interval, qry_resp_sec, response_interval;
  logic [47:0] prov_wr_mac, frm_dst, frm_src, out_dst, out_src;
  logic [3:0] frm_flow, out_flow;
  logic [22:0] rpt_group;
  logic [2:0] table_count;
  logic [1:0] mode;
  logic [mbf_pkg::ENT_W-1:0] exp_e;
  logic [mbf_pkg::ENT_W-1:0] exp_q[$];
  int err_count, cmp_count, exp_filt, got_filt, got_stale;
  integer seed = 32'heeaa68de;
  mbf_bridge #(.SEC_CYC(10), .STALE_CYC(8)) mbf_bridge_i (.*);
  mbf_sink_model mbf_sink_model_i (.clk(clk), .rst(rst), .mode(mode), .out_ready(out_ready));
  // ==========================================================
  // Clock, checks and drivers
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic stop_test();
    if (err_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic tmo();
    err_count++;
    stop_test();
  endtask
  task automatic chk_desc(input logic [mbf_pkg::ENT_W-1:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected frame at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Holds the offer until an edge finds room; valid stays up.
  task automatic offer(input logic fc, input logic [47:0] d, s, input logic [3:0] f,
                       input logic p, fwd);
    int n;
    n = 0;
    frm_from_cable = fc;
    frm_dst = d;
    frm_src = s;
    frm_flow = f;
    frm_policy_ok = p;
    frm_valid = 1'b1;
    while (frm_ready !== 1'b1) begin
      cyc(1);
      n++;
      if (n > 300) tmo();
    end
    if (fwd) exp_q.push_back({!fc, f, d, s});
    else exp_filt++;
    cyc(1);
  endtask
  task automatic send(input logic fc, input logic [47:0] d, s, input logic [3:0] f,
                      input logic p, fwd);
    offer(fc, d, s, f, p, fwd);
    frm_valid = 1'b0;
    cyc(1);
  endtask
  task automatic settle();
    int n;
    n = 0;
    while (exp_q.size() > 0) begin
      cyc(1);
      n++;
      if (n > 500) tmo();
    end
    cyc(4);
    chk_val(16'(got_filt), 16'(exp_filt));
  endtask
  task automatic prov(input logic [47:0] m);
    prov_wr_mac = m;
    prov_wr_valid = 1'b1;
    cyc(1);
    prov_wr_valid = 1'b0;
    cyc(2);
  endtask
  task automatic qry(input logic [7:0] r);
    qry_resp_sec = r;
    qry_valid = 1'b1;
    cyc(1);
    qry_valid = 1'b0;
    cyc(3);
  endtask
  task automatic do_reset();
    rst = 1'b1;
    exp_q.delete();
    exp_filt = 0;
    got_filt = 0;
    cyc(3);
    rst = 1'b0;
  endtask
  // Outputs are read settled at the falling edge against the oldest note.
  always @(negedge clk) begin
    if (rst === 1'b0) begin
      if (stale_drop === 1'b1) begin
        got_stale++;
        if (exp_q.size() > 0) void'(exp_q.pop_front());
      end
      if (filter_drop === 1'b1) got_filt++;
      if (out_valid === 1'b1 && out_ready === 1'b1) begin
        exp_e = '1;
        if (exp_q.size() > 0) exp_e = exp_q.pop_front();
        chk_desc({out_to_cable, out_flow, out_dst, out_src}, exp_e);
      end
    end
  end
  // ==========================================================
  // Main sequence
  initial begin
    {cfg_single_user, cfg_learn_en, cfg_override_en, prov_wr_valid, frm_valid} = '0;
    {frm_from_cable, frm_policy_ok, qry_valid, rpt_valid} = '0;
    {cfg_query_interval, cfg_response_interval, qry_resp_sec, rpt_group} = '0;
    {prov_wr_mac, frm_dst, frm_src, frm_flow} = '0;
    {mode, err_count, cmp_count, got_stale} = '0;
    do_reset();
    chk_val(16'(table_count), 16'h0000);
    chk_val(query_interval, mbf_pkg::QI_DEF_S);
    chk_val(16'(response_interval), 16'(mbf_pkg::RI_DEF_S));
    prov(MA);
    chk_val(16'(table_count), 16'h0001);
    send(1'b0, MX, MA, 4'h1, 1'b1, 1'b1);
    send(1'b0, mbf_pkg::BCAST_MAC, MA, 4'h1, 1'b1, 1'b1);
    send(1'b0, MG, MA, 4'h2, 1'b1, 1'b1);
    send(1'b0, MX, MB, 4'h1, 1'b1, 1'b0);
    send(1'b0, MB, MA, 4'h1, 1'b1, 1'b0);
    settle();
    send(1'b1, MA, MC, 4'h3, 1'b1, 1'b1);
    send(1'b1, MX, MC, 4'h3, 1'b1, 1'b0);
    send(1'b1, mbf_pkg::BCAST_MAC, MC, 4'h3, 1'b1, 1'b1);
    send(1'b1, mbf_pkg::BCAST_MAC, MA, 4'h3, 1'b1, 1'b0);
    send(1'b1, MG, MC, 4'h4, 1'b1, 1'b0);
    rpt_group = 23'h00_0007;
    rpt_valid = 1'b1;
    cyc(1);
    rpt_valid = 1'b0;
    send(1'b1, MG, MC, 4'h4, 1'b1, 1'b1);
    send(1'b1, MG, MC, 4'h4, 1'b0, 1'b0);
    settle();
    cyc(2300);
    send(1'b1, MG, MC, 4'h4, 1'b1, 1'b1);
    send(1'b1, MA, MC, 4'h3, 1'b1, 1'b1);
    cyc(500);
    send(1'b1, MG, MC, 4'h4, 1'b1, 1'b0);
    settle();
    cfg_learn_en = 1'b1;
    send(1'b0, MX, MD, 4'h5, 1'b1, 1'b1);
    send(1'b0, MX, ME, 4'h5, 1'b1, 1'b1);
    send(1'b0, MX, MF, 4'h5, 1'b1, 1'b1);
    cyc(2);
    chk_val(16'(table_full), 16'h0001);
    send(1'b0, MX, MH, 4'h5, 1'b1, 1'b0);
    prov(MP);
    send(1'b1, MP, MC, 4'h6, 1'b1, 1'b1);
    send(1'b1, MD, MC, 4'h6, 1'b1, 1'b0);
    settle();
    chk_val(16'(table_count), 16'h0004);
    // Random burst into a slow receiver must leave whole and in order.
    mode = 2'h1;
    for (int i = 0; i < 12; i++) begin
      offer(1'b0, {16'h0200, 32'($random(seed))}, MA, 4'($random(seed)), 1'b1, 1'b1);
    end
    frm_valid = 1'b0;
    settle();
    mode = 2'h2;
    for (int i = 0; i < 3; i++) begin
      offer(1'b0, MX, MA, 4'h7, 1'b1, 1'b1);
    end
    frm_valid = 1'b0;
    settle();
    chk_val(16'(got_stale), 16'h0003);
    mode = 2'h0;
    qry(8'h00);
    chk_val(query_interval, 16'h007D);
    chk_val(16'(response_interval), 16'h000A);
    cyc(1996);
    qry(8'h14);
    chk_val(query_interval, 16'h00C8);
    chk_val(16'(response_interval), 16'h0014);
    cyc(496);
    qry(8'h00);
    chk_val(query_interval, 16'h007D);
    cfg_query_interval = 16'h0030;
    cfg_response_interval = 8'h05;
    cfg_override_en = 1'b1;
    cyc(3);
    chk_val(query_interval, 16'h0030);
    chk_val(16'(response_interval), 16'h0005);
    cfg_override_en = 1'b0;
    cfg_single_user = 1'b1;
    do_reset();
    send(1'b1, MA, MC, 4'h3, 1'b1, 1'b0);
    prov(MA);
    chk_val(16'(table_full), 16'h0001);
    send(1'b0, MX, MB, 4'h1, 1'b1, 1'b0);
    send(1'b0, MX, MA, 4'h1, 1'b1, 1'b1);
    settle();
    stop_test();
  end
endmodule // mbf_bridge_tb_top

/* File: verif/mbf_sink_model.sv */
// Receiver of forwarded frames: prompt, slow or stalled.
module mbf_sink_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] mode,
  output logic out_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] cnt_ff;
  // Slow mode takes one cycle in four, so the buffer must absorb the gaps.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= 3'h0;
      out_ready <= 1'b0;
    end else begin
      cnt_ff <= cnt_ff + 3'h1;
      out_ready <= #1 (mode == 2'h0) || (mode == 2'h1 && cnt_ff[1:0] == 2'h3);
    end
  end
endmodule // mbf_sink_model
